// [slp_pkg.sv]
/*
  Shared constants and types of the serial instruction port: opcodes,
  RAM address map, timing counts and state enumerations.
  Assumes a 40 MHz system clock on both ends.
*/
package slp_pkg;
  localparam logic [4:0] WORD_BITS = 5'h10;
  localparam logic [4:0] OPCODE_BITS = 5'h08;
  localparam logic [3:0] HOST_LAST_BIT = 4'hf;
  localparam logic [3:0] HOST_FIRST_RX_BIT = 4'h8;

  localparam logic [7:0] OP_WRITE = 8'h98;
  localparam logic [7:0] OP_SET_DDMK = 8'h93;
  localparam logic [7:0] OP_SET_GLYPH = 8'h90;
  // Key read opcode value is arbitrary
  localparam logic [7:0] OP_KEY_READ = 8'h8f;

  localparam logic [7:0] DD_LAST = 8'h0d;
  localparam logic [7:0] MK_FIRST = 8'h10;
  localparam logic [7:0] MK_LAST = 8'h1d;
  localparam logic [7:0] MK_HIDDEN_A = 8'h1c;
  localparam logic [7:0] MK_HIDDEN_B = 8'h1d;
  localparam logic [7:0] DDMK_ADDR_MASK = 8'h1f;
  localparam int DD_WORDS = 14;
  localparam int MK_WORDS = 14;
  localparam int GLYPH_WORDS = 256;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] KEY_IDLE = 8'hff;

  localparam int CLK_PERIOD_NS = 25;
  localparam int OSC_PERIOD_NS = 6900;
  localparam int OSC_DIV_CYC = OSC_PERIOD_NS / CLK_PERIOD_NS;
  localparam int FRAME_LINES = 224;
  localparam int FRAME_PHASES = 8;
  localparam int FRAME_OSC_PERIODS = FRAME_LINES * FRAME_PHASES;

  localparam int SCK_HALF_NS = 500;
  localparam logic [7:0] SCK_HALF_CYC =
    8'((SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

  localparam logic [1:0] RD_SEL_DD = 2'h0;
  localparam logic [1:0] RD_SEL_MK = 2'h1;
  localparam logic [1:0] RD_SEL_GLYPH = 2'h2;

  typedef enum logic {SLP_RAM_DDMK, SLP_RAM_GLYPH} slp_ram_e;
  typedef enum logic [2:0] {
    SLP_H_IDLE, SLP_H_SETUP, SLP_H_HIGH, SLP_H_LOW, SLP_H_HOLD, SLP_H_GAP
  } slp_host_state_e;
endpackage

// [slp_link_if.sv]
/*
  Link between host and display controller: select, shift clock and one
  shared data pin. Assumes a pull-up: the pin reads high when undriven.
*/
`timescale 1ns/10ps
interface slp_link_if;
  logic chip_select_low;
  logic sck;
  logic host_sda;
  logic host_sda_oe;
  logic dev_sda;
  logic dev_sda_oe;
  logic sda;

  // Device wins if both drive; the host must release first
  assign sda = dev_sda_oe ? dev_sda : (host_sda_oe ? host_sda : 1'b1);

  modport device(input chip_select_low, input sck, input sda,
                 output dev_sda, output dev_sda_oe);
  modport host(output chip_select_low, output sck, output host_sda,
               output host_sda_oe, input sda);
endinterface

// [slp_device.sv]
/*
  Display controller end: serial receiver on the shift clock, instruction
  execution with display, icon and glyph RAMs on the oscillator clock,
  key data turn-around and display frame timing.
  Assumes the host holds the select high for at least four clk_in cycles
  between frames and keeps key_data_in steady during a frame.
*/
`timescale 1ns/10ps
// Contract
// - Write opcode to display RAM stores eight bits
// - Glyph and icon writes keep only five bits
// - Write goes to last address-selected RAM
// - Pointer steps up or down after write
// - Display shift after write when entry asks
// - Icon 1C and 1D stored, hidden, pointer steps
// - Key read: pin becomes output at eighth fall
// - Shift clock accepted only while select low
// - Word is sixteen bits, one select frame
// - Data sampled on shift clock rising edge
// - Word executed at rising select edge only
// - Bits past sixteen ignored
// - Short frame discarded, nothing executed
// - Host gives exactly sixteen clocks per frame
// - Most significant bit first
// - Host releases data pin when device drives
// - Frame lasts 224 times 8 oscillator periods
// - Host initialises by instruction if needed
// - Display/icon address set loads 5-bit address
// - Glyph address set loads 8 bits, selects glyph
module slp_device #(
  parameter int OSC_DIV = slp_pkg::OSC_DIV_CYC,
  parameter int FRAME_OSC = slp_pkg::FRAME_OSC_PERIODS
) (
  input wire logic clk_in,
  input wire logic nrst_in,
  slp_link_if.device lnk,
  input wire logic entry_increment_in,
  input wire logic entry_shift_in,
  input wire logic [7:0] key_data_in,
  input wire logic [1:0] rd_sel_in,
  input wire logic [7:0] rd_addr_in,
  output logic [7:0] rd_data_out,
  output logic [7:0] address_pointer_out,
  output logic glyph_selected_out,
  output logic disp_shift_out,
  output logic disp_update_out,
  output logic frame_tick_out
);
  logic [7:0] display_data_ram [slp_pkg::DD_WORDS];
  logic [4:0] icon_mark_ram [slp_pkg::MK_WORDS];
  logic [4:0] user_glyph_ram [slp_pkg::GLYPH_WORDS];

  // Shift clock domain
  logic frame_tog_reg;
  logic seen_tog_reg;
  logic [4:0] bit_cnt_reg;
  logic [15:0] word_reg;
  logic [6:0] key_shift_reg;
  logic dev_sda_reg;
  logic dev_oe_reg;

  // Oscillator clock domain
  logic cs_s1_reg;
  logic cs_s2_reg;
  logic cs_prev_reg;
  logic [7:0] key_hold_reg;
  logic [7:0] ptr_reg;
  slp_pkg::slp_ram_e ram_kind_reg;
  logic [7:0] rd_data_reg;
  logic shift_reg;
  logic update_reg;
  logic frame_reg;
  logic [15:0] osc_cnt_reg;
  logic [15:0] line_cnt_reg;

  function automatic logic [7:0] ptr_step(input logic [7:0] p,
                                          input logic up,
                                          input logic glyph);
    logic [7:0] n;
    n = up ? 8'(p + 8'h01) : 8'(p - 8'h01);
    ptr_step = glyph ? n : (n & slp_pkg::DDMK_ADDR_MASK);
  endfunction

  // Select falls toggle a frame marker; the first shift edge of the next
  // frame sees a new value and restarts the count.
  always_ff @(negedge lnk.chip_select_low or negedge nrst_in) begin
    if (!nrst_in) begin
      frame_tog_reg <= 1'b0;
    end else begin
      frame_tog_reg <= ~frame_tog_reg;
    end
  end

  wire new_frame = frame_tog_reg != seen_tog_reg;
  wire cnt_full = bit_cnt_reg == slp_pkg::WORD_BITS;

  always_ff @(posedge lnk.sck or negedge nrst_in) begin
    if (!nrst_in) begin
      seen_tog_reg <= 1'b0;
      bit_cnt_reg <= 5'h00;
      word_reg <= 16'h0000;
    end else if (!lnk.chip_select_low) begin
      if (new_frame) begin
        seen_tog_reg <= frame_tog_reg;
        bit_cnt_reg <= 5'h01;
        word_reg <= {15'h0000, lnk.sda};
      end else if (!cnt_full) begin
        bit_cnt_reg <= 5'(bit_cnt_reg + 5'h01);
        word_reg <= {word_reg[14:0], lnk.sda};
      end
    end
  end

  wire key_turn = !lnk.chip_select_low && !new_frame &&
                  bit_cnt_reg == slp_pkg::OPCODE_BITS &&
                  word_reg[7:0] == slp_pkg::OP_KEY_READ;

  // Driving stops as soon as the select rises, so the pin is free between
  // frames without waiting for a shift clock edge.
  always_ff @(negedge lnk.sck or negedge nrst_in
              or posedge lnk.chip_select_low) begin
    if (!nrst_in) begin
      dev_oe_reg <= 1'b0;
      dev_sda_reg <= 1'b1;
      key_shift_reg <= 7'h7f;
    end else if (lnk.chip_select_low) begin
      dev_oe_reg <= 1'b0;
      dev_sda_reg <= 1'b1;
      key_shift_reg <= 7'h7f;
    end else if (key_turn) begin
      dev_oe_reg <= 1'b1;
      dev_sda_reg <= key_hold_reg[7];
      key_shift_reg <= key_hold_reg[6:0];
    end else if (dev_oe_reg) begin
      dev_sda_reg <= key_shift_reg[6];
      key_shift_reg <= {key_shift_reg[5:0], 1'b1};
    end
  end

  assign lnk.dev_sda = dev_sda_reg;
  assign lnk.dev_sda_oe = dev_oe_reg;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      cs_s1_reg <= 1'b1;
      cs_s2_reg <= 1'b1;
      cs_prev_reg <= 1'b1;
    end else begin
      cs_s1_reg <= lnk.chip_select_low;
      cs_s2_reg <= cs_s1_reg;
      cs_prev_reg <= cs_s2_reg;
    end
  end

  // Word and count are static once the select is high and the clock idle
  wire cs_rise = cs_s2_reg && !cs_prev_reg;
  // A frame with no shift edges keeps the old count; the unseen frame
  // marker stops that stale word from being executed a second time.
  wire exec = cs_rise && cnt_full && !new_frame;
  wire [7:0] op = word_reg[15:8];
  wire [7:0] arg = word_reg[7:0];
  wire do_write = exec && op == slp_pkg::OP_WRITE;
  wire do_set_ddmk = exec && op == slp_pkg::OP_SET_DDMK;
  wire do_set_glyph = exec && op == slp_pkg::OP_SET_GLYPH;
  wire glyph_sel = ram_kind_reg == slp_pkg::SLP_RAM_GLYPH;
  wire in_dd = ptr_reg <= slp_pkg::DD_LAST;
  wire in_mk = ptr_reg >= slp_pkg::MK_FIRST && ptr_reg <= slp_pkg::MK_LAST;
  wire mk_hidden = ptr_reg == slp_pkg::MK_HIDDEN_A ||
                   ptr_reg == slp_pkg::MK_HIDDEN_B;
  wire [3:0] ddmk_idx = ptr_reg[3:0];
  wire wr_dd = do_write && !glyph_sel && in_dd;
  wire wr_mk = do_write && !glyph_sel && in_mk;
  wire wr_glyph = do_write && glyph_sel;
  wire shows = wr_glyph || wr_dd || (wr_mk && !mk_hidden);

  always_ff @(posedge clk_in) begin
    if (wr_dd) begin
      display_data_ram[ddmk_idx] <= arg;
    end
    if (wr_mk) begin
      icon_mark_ram[ddmk_idx] <= arg[4:0];
    end
    if (wr_glyph) begin
      user_glyph_ram[ptr_reg] <= arg[4:0];
    end
  end

  wire [4:0] rd_idx_mk = 5'(rd_addr_in - slp_pkg::MK_FIRST);
  wire rd_dd_ok = rd_addr_in <= slp_pkg::DD_LAST;
  wire rd_mk_ok = rd_addr_in >= slp_pkg::MK_FIRST &&
                  rd_addr_in <= slp_pkg::MK_LAST;
  wire [7:0] rd_value =
    (rd_sel_in == slp_pkg::RD_SEL_DD && rd_dd_ok) ?
      display_data_ram[rd_addr_in[3:0]] :
    (rd_sel_in == slp_pkg::RD_SEL_MK && rd_mk_ok) ?
      {3'h0, icon_mark_ram[rd_idx_mk[3:0]]} :
    (rd_sel_in == slp_pkg::RD_SEL_GLYPH) ?
      {3'h0, user_glyph_ram[rd_addr_in]} : 8'h00;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rd_data_reg <= 8'h00;
      key_hold_reg <= slp_pkg::KEY_IDLE;
    end else begin
      rd_data_reg <= rd_value;
      if (cs_s2_reg) begin
        key_hold_reg <= key_data_in;
      end
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      ptr_reg <= slp_pkg::PTR_RESET;
      ram_kind_reg <= slp_pkg::SLP_RAM_DDMK;
      shift_reg <= 1'b0;
      update_reg <= 1'b0;
    end else begin
      shift_reg <= do_write && entry_shift_in;
      update_reg <= shows;
      if (do_set_ddmk) begin
        ptr_reg <= arg & slp_pkg::DDMK_ADDR_MASK;
        ram_kind_reg <= slp_pkg::SLP_RAM_DDMK;
      end else if (do_set_glyph) begin
        ptr_reg <= arg;
        ram_kind_reg <= slp_pkg::SLP_RAM_GLYPH;
      end else if (do_write) begin
        ptr_reg <= ptr_step(ptr_reg, entry_increment_in, glyph_sel);
      end
    end
  end

  wire osc_wrap = osc_cnt_reg == 16'(OSC_DIV - 1);
  wire line_wrap = line_cnt_reg == 16'(FRAME_OSC - 1);

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      osc_cnt_reg <= 16'h0000;
      line_cnt_reg <= 16'h0000;
      frame_reg <= 1'b0;
    end else begin
      osc_cnt_reg <= osc_wrap ? 16'h0000 : 16'(osc_cnt_reg + 16'h0001);
      frame_reg <= osc_wrap && line_wrap;
      if (osc_wrap) begin
        line_cnt_reg <= line_wrap ? 16'h0000 :
                        16'(line_cnt_reg + 16'h0001);
      end
    end
  end

  assign rd_data_out = rd_data_reg;
  assign address_pointer_out = ptr_reg;
  assign glyph_selected_out = glyph_sel;
  assign disp_shift_out = shift_reg;
  assign disp_update_out = update_reg;
  assign frame_tick_out = frame_reg;
endmodule // slp_device

// [slp_host.sv]
/*
  Host end: sends one 16-bit word per select frame, MSB first, on a shift
  clock divided from clk_in; for the key read opcode it releases the pin
  after eight bits and collects eight key bits.
  Assumes the user holds cmd_word_in while cmd_valid_in is high.
*/
`timescale 1ns/10ps
module slp_host (
  input wire logic clk_in,
  input wire logic nrst_in,
  slp_link_if.host lnk,
  input wire logic cmd_valid_in,
  input wire logic [15:0] cmd_word_in,
  output logic cmd_ready_out,
  output logic done_out,
  output logic [7:0] key_data_out,
  output logic key_valid_out
);
  slp_pkg::slp_host_state_e state_reg;
  logic [15:0] tx_reg;
  logic [7:0] rx_reg;
  logic [3:0] bit_reg;
  logic [7:0] timer_reg;
  logic is_key_reg;
  logic cs_reg;
  logic sck_reg;
  logic sda_reg;
  logic oe_reg;
  logic ready_reg;
  logic done_reg;
  logic [7:0] key_reg;
  logic key_valid_reg;
  logic sda_s1_reg;
  logic sda_s2_reg;

  wire tick = timer_reg == 8'h00;
  wire [3:0] bit_next = 4'(bit_reg + 4'h1);
  wire rx_phase = is_key_reg && bit_reg >= slp_pkg::HOST_FIRST_RX_BIT;

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
    end else begin
      sda_s1_reg <= lnk.sda;
      sda_s2_reg <= sda_s1_reg;
    end
  end

  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      state_reg <= slp_pkg::SLP_H_IDLE;
      tx_reg <= 16'h0000;
      rx_reg <= 8'h00;
      bit_reg <= 4'h0;
      timer_reg <= 8'h00;
      is_key_reg <= 1'b0;
      cs_reg <= 1'b1;
      sck_reg <= 1'b0;
      sda_reg <= 1'b1;
      oe_reg <= 1'b0;
      ready_reg <= 1'b0;
      done_reg <= 1'b0;
      key_reg <= 8'h00;
      key_valid_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      key_valid_reg <= 1'b0;
      timer_reg <= tick ? 8'h00 : 8'(timer_reg - 8'h01);
      case (state_reg)
        slp_pkg::SLP_H_IDLE: begin
          ready_reg <= 1'b1;
          if (cmd_valid_in && ready_reg) begin
            ready_reg <= 1'b0;
            tx_reg <= cmd_word_in;
            is_key_reg <= cmd_word_in[15:8] == slp_pkg::OP_KEY_READ;
            bit_reg <= 4'h0;
            cs_reg <= 1'b0;
            sda_reg <= cmd_word_in[15];
            oe_reg <= 1'b1;
            timer_reg <= 8'(slp_pkg::SCK_HALF_CYC - 8'h01);
            state_reg <= slp_pkg::SLP_H_SETUP;
          end
        end
        slp_pkg::SLP_H_SETUP, slp_pkg::SLP_H_LOW: begin
          if (tick) begin
            if (rx_phase) begin
              rx_reg <= {rx_reg[6:0], sda_s2_reg};
            end
            sck_reg <= 1'b1;
            timer_reg <= 8'(slp_pkg::SCK_HALF_CYC - 8'h01);
            state_reg <= slp_pkg::SLP_H_HIGH;
          end
        end
        slp_pkg::SLP_H_HIGH: begin
          if (tick) begin
            sck_reg <= 1'b0;
            timer_reg <= 8'(slp_pkg::SCK_HALF_CYC - 8'h01);
            if (bit_reg == slp_pkg::HOST_LAST_BIT) begin
              state_reg <= slp_pkg::SLP_H_HOLD;
            end else begin
              bit_reg <= bit_next;
              tx_reg <= {tx_reg[14:0], 1'b0};
              sda_reg <= tx_reg[14];
              // Release exactly as the eighth falling edge goes out
              oe_reg <= !(is_key_reg &&
                          bit_next >= slp_pkg::HOST_FIRST_RX_BIT);
              state_reg <= slp_pkg::SLP_H_LOW;
            end
          end
        end
        slp_pkg::SLP_H_HOLD: begin
          if (tick) begin
            cs_reg <= 1'b1;
            oe_reg <= 1'b0;
            timer_reg <= 8'(slp_pkg::SCK_HALF_CYC - 8'h01);
            state_reg <= slp_pkg::SLP_H_GAP;
          end
        end
        slp_pkg::SLP_H_GAP: begin
          if (tick) begin
            done_reg <= 1'b1;
            key_valid_reg <= is_key_reg;
            if (is_key_reg) begin
              key_reg <= rx_reg;
            end
            state_reg <= slp_pkg::SLP_H_IDLE;
          end
        end
        default: begin
          state_reg <= slp_pkg::SLP_H_IDLE;
        end
      endcase
    end
  end

  assign lnk.chip_select_low = cs_reg;
  assign lnk.sck = sck_reg;
  assign lnk.host_sda = sda_reg;
  assign lnk.host_sda_oe = oe_reg;
  assign cmd_ready_out = ready_reg;
  assign done_out = done_reg;
  assign key_data_out = key_reg;
  assign key_valid_out = key_valid_reg;
endmodule // slp_host

// [slp_link_props.sv]
/*
  Link checker: timing and ownership properties of the host-device link.
  Assumes clk_in samples the link and nrst_in resets both ends.
*/
`timescale 1ns/10ps
module slp_link_props (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic chip_select_low,
  input wire logic sck,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic sda
);
  logic sck_reg;
  logic [4:0] rise_reg;
  logic [4:0] fall_reg;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);

  // Edge counts restart while the select is high
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      sck_reg <= 1'b0;
      rise_reg <= 5'h00;
      fall_reg <= 5'h00;
    end else begin
      sck_reg <= sck;
      rise_reg <= chip_select_low ? 5'h00 : rise_reg + 5'(sck & ~sck_reg);
      fall_reg <= chip_select_low ? 5'h00 : fall_reg + 5'(~sck & sck_reg);
    end
  end

  a_oe_idle_off: assert property (chip_select_low |-> !dev_sda_oe)
    else $error("device drives data pin outside a frame");
  a_sck_idle_low: assert property (chip_select_low |-> !sck)
    else $error("shift clock active while select high");
  a_no_contention: assert property (!(host_sda_oe && dev_sda_oe))
    else $error("both ends drive the data pin");
  a_oe_eighth_fall: assert property ($rose(dev_sda_oe) |->
    $fell(sck) && fall_reg == 5'h07)
    else $error("turn-around not at eighth falling edge");
  a_sck_half_high: assert property ($rose(sck) |-> ##20 $fell(sck))
    else $error("shift clock high phase wrong");
  a_sixteen_rises: assert property ($rose(chip_select_low) |->
    rise_reg == 5'h10)
    else $error("frame without sixteen shift clocks");
  a_oe_held_frame: assert property (dev_sda_oe && !chip_select_low |=>
    dev_sda_oe || chip_select_low)
    else $error("device released pin inside frame");
  a_first_bit_on: assert property ($fell(chip_select_low) |->
    host_sda_oe && !sck)
    else $error("first bit not presented at select fall");
  a_sda_stable_hi: assert property (sck && $past(sck) |-> $stable(sda))
    else $error("data moved while shift clock high");

  c_key_turn: cover property ($rose(dev_sda_oe));
  c_full_frame: cover property ($rose(chip_select_low) && rise_reg == 5'h10);
  c_back_to_back: cover property ($rose(chip_select_low) ##[1:100]
    $fell(chip_select_low));
endmodule // slp_link_props

// [serial_lcd_instruction_port_tb.sv]
/*
  Bench: host and device joined on one link, plus a second device fed by
  a bit-banged link for malformed frames.
  Assumes the slp_pkg opcodes and a small frame timer setting.
*/
`timescale 1ns/10ps
module serial_lcd_instruction_port_tb;
  localparam int DIV = 2;
  localparam int FOSC = 4;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b1;
  logic cmd_valid = 1'b0;
  logic [15:0] cmd_word = 16'h0000;
  logic entry_inc = 1'b1;
  logic entry_shift = 1'b0;
  logic [7:0] key_data = 8'h00;
  logic [1:0] rd_sel = 2'h0;
  logic [7:0] rd_addr = 8'h00;
  logic cmd_ready, done, key_valid, glyph_sel, dshift, dupd, ftick;
  logic [7:0] key_out, rd_data, ptr, ptr_b;
  logic [7:0] got_key = 8'h00;
  int n_fail = 0;
  int check_count = 0;
  int n_upd = 0;
  int n_shift = 0;
  int since = 0;
  int gap = 0;
  int u;
  slp_link_if lk();
  slp_link_if lk2();

  always #12.5 clk_in = ~clk_in;

  slp_host i_slp_host (.clk_in(clk_in), .nrst_in(nrst_in), .lnk(lk.host),
    .cmd_valid_in(cmd_valid), .cmd_word_in(cmd_word),
    .cmd_ready_out(cmd_ready), .done_out(done), .key_data_out(key_out),
    .key_valid_out(key_valid));
  slp_device #(.OSC_DIV(DIV), .FRAME_OSC(FOSC)) i_slp_device (
    .clk_in(clk_in), .nrst_in(nrst_in), .lnk(lk.device),
    .entry_increment_in(entry_inc), .entry_shift_in(entry_shift),
    .key_data_in(key_data), .rd_sel_in(rd_sel), .rd_addr_in(rd_addr),
    .rd_data_out(rd_data), .address_pointer_out(ptr),
    .glyph_selected_out(glyph_sel), .disp_shift_out(dshift),
    .disp_update_out(dupd), .frame_tick_out(ftick));
  // Second device takes malformed frames from the bench
  slp_device #(.OSC_DIV(DIV), .FRAME_OSC(FOSC)) i_slp_device_b (
    .clk_in(clk_in), .nrst_in(nrst_in), .lnk(lk2.device),
    .entry_increment_in(entry_inc), .entry_shift_in(entry_shift),
    .key_data_in(key_data), .rd_sel_in(rd_sel), .rd_addr_in(rd_addr),
    .rd_data_out(), .address_pointer_out(ptr_b), .glyph_selected_out(),
    .disp_shift_out(), .disp_update_out(), .frame_tick_out());
  slp_link_props u_props (.clk_in(clk_in), .nrst_in(nrst_in),
    .chip_select_low(lk.chip_select_low), .sck(lk.sck),
    .host_sda_oe(lk.host_sda_oe), .dev_sda_oe(lk.dev_sda_oe), .sda(lk.sda));

  initial begin
    lk2.chip_select_low = 1'b1;
    lk2.sck = 1'b0;
    lk2.host_sda = 1'b1;
    lk2.host_sda_oe = 1'b0;
  end

  // Pulses are registers, so the pre-edge value is the settled one
  always @(posedge clk_in) begin
    n_upd += int'(dupd === 1'b1);
    n_shift += int'(dshift === 1'b1);
    gap = (ftick === 1'b1) ? since + 1 : gap;
    since = (ftick === 1'b1) ? 0 : since + 1;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic wait_hi(ref logic sig, input int lim);
    repeat (lim) if (sig !== 1'b1) @(negedge clk_in);
    if (sig !== 1'b1) begin
      n_fail++;
      $display("[ERR] t=%0t wait expired got %h exp %h", $time, 0, 1);
      complete_run();
    end
  endtask

  task automatic send(input logic [15:0] w);
    wait_hi(cmd_ready, 60);
    @(posedge clk_in);
    cmd_valid <= 1'b1;
    cmd_word <= w;
    @(posedge clk_in);
    cmd_valid <= 1'b0;
    wait_hi(done, 800);
    if (key_valid === 1'b1) begin
      got_key = key_out;
    end
  endtask

  task automatic rd(input logic [1:0] s, input logic [7:0] a,
                    input logic [7:0] e);
    @(posedge clk_in);
    rd_sel <= s;
    rd_addr <= a;
    @(posedge clk_in);
    @(negedge clk_in);
    check(rd_data, e);
  endtask

  // Bench plays the host on the second link, 125 ns shift clock
  task automatic bang(input logic [19:0] w, input int nb);
    logic [7:0] p0;
    p0 = ptr_b;
    #7 lk2.chip_select_low = 1'b0;
    lk2.host_sda_oe = 1'b1;
    for (int i = 19; i > 19 - nb; i--) begin
      lk2.host_sda = w[i];
      #62.5 lk2.sck = 1'b1;
      #62.5 lk2.sck = 1'b0;
    end
    repeat (8) @(negedge clk_in);
    check(ptr_b, p0);
    lk2.chip_select_low = 1'b1;
    lk2.host_sda_oe = 1'b0;
    repeat (10) @(negedge clk_in);
  endtask

  initial begin
    // A real falling edge, so flops on the link clocks also reset
    nrst_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    nrst_in <= 1'b1;
    @(negedge clk_in);
    check(ptr, slp_pkg::PTR_RESET);
    send({slp_pkg::OP_SET_DDMK, 8'he2});
    check(ptr, 8'h02);
    u = n_upd;
    send({slp_pkg::OP_WRITE, 8'ha5});
    check(ptr, 8'h03);
    check(8'(n_upd - u), 8'h01);
    rd(slp_pkg::RD_SEL_DD, 8'h02, 8'ha5);
    rd(2'h3, 8'h02, 8'h00);
    check(8'(n_shift), 8'h00);
    $display("test display write done");
    @(posedge clk_in);
    entry_inc <= 1'b0;
    entry_shift <= 1'b1;
    u = n_shift;
    send({slp_pkg::OP_WRITE, 8'h3c});
    check(ptr, 8'h02);
    check(8'(n_shift - u), 8'h01);
    rd(slp_pkg::RD_SEL_DD, 8'h03, 8'h3c);
    $display("test decrement and shift done");
    @(posedge clk_in);
    entry_inc <= 1'b1;
    entry_shift <= 1'b0;
    send({slp_pkg::OP_SET_DDMK, slp_pkg::MK_HIDDEN_A});
    u = n_upd;
    send({slp_pkg::OP_WRITE, 8'hff});
    send({slp_pkg::OP_WRITE, 8'h0b});
    check(8'(n_upd - u), 8'h00);
    check(ptr, 8'h1e);
    rd(slp_pkg::RD_SEL_MK, slp_pkg::MK_HIDDEN_A, 8'h1f);
    rd(slp_pkg::RD_SEL_MK, slp_pkg::MK_HIDDEN_B, 8'h0b);
    $display("test icon write done");
    send({slp_pkg::OP_SET_GLYPH, 8'h02});
    check({7'h00, glyph_sel}, 8'h01);
    u = n_upd;
    send({slp_pkg::OP_WRITE, 8'hf7});
    check(ptr, 8'h03);
    check(8'(n_upd - u), 8'h01);
    rd(slp_pkg::RD_SEL_GLYPH, 8'h02, 8'h17);
    rd(slp_pkg::RD_SEL_DD, 8'h02, 8'ha5);
    send({slp_pkg::OP_SET_DDMK, 8'h00});
    check({7'h00, glyph_sel}, 8'h00);
    $display("test glyph write done");
    @(posedge clk_in);
    key_data <= 8'hb4;
    send({slp_pkg::OP_KEY_READ, 8'h00});
    check(got_key, 8'hb4);
    @(posedge clk_in);
    key_data <= 8'h4b;
    send({slp_pkg::OP_KEY_READ, 8'h00});
    check(got_key, 8'h4b);
    check(ptr, 8'h00);
    $display("test key read done");
    check(8'(gap), 8'(DIV * FOSC));
    $display("test frame timer done");
    bang({slp_pkg::OP_SET_DDMK, 8'h07, 4'h0}, 15);
    check(ptr_b, 8'h00);
    bang({slp_pkg::OP_SET_DDMK, 8'h09, 4'ha}, 20);
    check(ptr_b, 8'h09);
    bang({slp_pkg::OP_WRITE, 8'h11, 4'h0}, 16);
    check(ptr_b, 8'h0a);
    bang(20'h00000, 0);
    check(ptr_b, 8'h0a);
    $display("test malformed frames done");
    complete_run();
  end
endmodule // serial_lcd_instruction_port_tb
